// >>> rtl/sts_pkg.sv
package sts_pkg;

  // clock and the one-second tick
  localparam int unsigned CLOCK_HZ        = 50_000_000;
  localparam int unsigned TICK_SECONDS    = 1;
  localparam int unsigned TICK_CYCLES     = CLOCK_HZ * TICK_SECONDS;
  // 1/2 Hz blink: two seconds a period, one second each phase
  localparam int unsigned BLINK_HZ_DEN    = 2;
  localparam int unsigned BLINK_HALF_TICKS = BLINK_HZ_DEN / 2;

  // delay counter width in bits; the count is in seconds
  localparam int unsigned DELAY_W         = 16;
  localparam logic [15:0] DELAY_ZERO      = 16'h0000;

  // event code flash-out timing, in ticks
  localparam logic [3:0]  FLASH_ON_TICKS  = 4'h1;
  localparam logic [3:0]  FLASH_GAP_TICKS = 4'h3;
  localparam int unsigned CODE_W          = 4;

  typedef struct packed {
    logic under_volt;
    logic over_volt;
    logic freq_bad;
    logic rotation_bad;
    logic phase_loss;
  } sts_sensor_t;

  typedef struct packed {
    logic [15:0] engine_start;
    logic [15:0] transfer;
    logic [15:0] retransfer;
    logic [15:0] transition;
    logic [15:0] cooldown;
  } sts_delays_t;

  typedef struct packed {
    logic health;
    logic src1_avail;
    logic src2_avail;
    logic start_src2;
    logic start_src1;
    logic retransfer;
    logic transfer;
    logic transition;
    logic exerciser;
    logic spare;
  } sts_leds_t;

  typedef enum logic [10:0] {
    ST_ON_SRC1    = 11'h001,
    ST_ES_DELAY   = 11'h002,
    ST_WAIT_SRC2  = 11'h004,
    ST_XFER_DELAY = 11'h008,
    ST_TO_NEUT_A  = 11'h010,
    ST_PT_A       = 11'h020,
    ST_TO_SRC2    = 11'h040,
    ST_ON_SRC2    = 11'h080,
    ST_RXFER_DLY  = 11'h100,
    ST_TO_NEUT_B  = 11'h200,
    ST_PT_B       = 11'h400
  } sts_state_t;

endpackage

// >>> rtl/sts_delay.sv
`timescale 1ns/10ps
`default_nettype none
module sts_delay #(
  parameter int unsigned W = 16
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rstn,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  input  wire logic         abort,
  input  wire logic         tick,
  // status
  output logic              running,
  output logic              expired
);

  logic [W-1:0] count;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count   <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (abort) begin
        count   <= '0;
        running <= 1'b0;
      end else if (load) begin
        count   <= value;
        running <= 1'b1;
      end else if (running && count == '0) begin
        // zero setup expires on the next edge without waiting a tick
        running <= 1'b0;
        expired <= 1'b1;
      end else if (running && tick) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// >>> rtl/sts_flasher.sv
`timescale 1ns/10ps
`default_nettype none
module sts_flasher #(
  parameter int unsigned CW = 4
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          rstn,
  // control
  input  wire logic          tick,
  input  wire logic          active,
  input  wire logic [CW-1:0] code,
  // led
  output logic               led
);

  // code flashed as N one-tick pulses, then a longer pause
  logic [CW-1:0] left;
  logic [3:0]    gap;
  logic          phase_on;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      left     <= '0;
      gap      <= 4'h0;
      phase_on <= 1'b0;
      led      <= 1'b0;
    end else if (!active) begin
      left     <= '0;
      gap      <= 4'h0;
      phase_on <= 1'b0;
      led      <= 1'b0;
    end else if (tick) begin
      if (phase_on) begin
        phase_on <= 1'b0;
        led      <= 1'b0;
      end else if (left != '0) begin
        left     <= left - 1'b1;
        phase_on <= 1'b1;
        led      <= 1'b1;
      end else if (gap != 4'h0) begin
        gap <= gap - 1'b1;
      end else begin
        left <= code;
        gap  <= sts_pkg::FLASH_GAP_TICKS;
      end
    end
  end

endmodule
`default_nettype wire

// >>> rtl/sts_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module sts_sequencer #(
  parameter int unsigned TICK_CYCLES = sts_pkg::TICK_CYCLES,
  parameter int unsigned DW          = sts_pkg::DELAY_W
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rstn,
  // source sensing
  input  wire sts_pkg::sts_sensor_t src1_sense,
  input  wire logic                 src2_ok,
  // setup
  input  wire sts_pkg::sts_delays_t delays,
  input  wire logic                 programmed_transition,
  input  wire logic                 gen_to_gen,
  // position switches, high while closed
  input  wire logic                 neutral_limit_on_transfer,
  input  wire logic                 src2_limit_switch,
  input  wire logic                 neutral_limit_on_retransfer,
  input  wire logic                 src1_limit_switch,
  input  wire logic                 at_neutral,
  // events and operator
  input  wire logic                 event_raise,
  input  wire logic [3:0]           event_code,
  input  wire logic                 panel_reset,
  input  wire logic                 exer_switch_toggle,
  input  wire logic                 exer_remote_set,
  input  wire logic                 exer_remote_value,
  input  wire logic                 exercise_period,
  // relays, high energised
  output logic                      engine_start_relay,
  output logic                      transfer_motor_relay,
  output logic                      retransfer_motor_relay,
  output logic                      transition_motor_relay,
  // status
  output logic                      src1_connected,
  output logic                      src2_connected,
  output logic                      event_active,
  output logic                      exerciser_enabled,
  output sts_pkg::sts_leds_t        leds
);

  sts_pkg::sts_state_t state;
  logic [31:0] tick_cnt;
  logic        tick;
  logic        blink;
  logic        src1_ok;
  logic        src2_started;
  logic        cooling;
  logic [3:0]  held_code;
  logic        flash_led;

  logic es_load, es_run, es_exp;
  logic xf_load, xf_run, xf_exp;
  logic rx_load, rx_run, rx_exp;
  logic pt_load, pt_run, pt_exp;
  logic cd_load, cd_run, cd_exp;
  logic es_abort, xf_abort, rx_abort;
  logic [DW-1:0] pt_value;
  logic          pt_counts;

  // any one sensor out of limits is enough to fail the source
  assign src1_ok = ~|src1_sense;

  // one-second tick and the 1/2 Hz blink phase
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b0;
    end else if (tick_cnt == TICK_CYCLES - 1) begin
      tick_cnt <= 32'h0000_0000;
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      tick     <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      blink <= 1'b0;
    end else if (tick) begin
      blink <= ~blink;
    end
  end

  // delay loads follow state entry; aborts when the cause goes away
  assign es_load  = (state == sts_pkg::ST_ON_SRC1) && !src1_ok;
  assign es_abort = (state == sts_pkg::ST_ES_DELAY) && src1_ok;
  assign xf_load  = (state == sts_pkg::ST_WAIT_SRC2) && src2_ok;
  assign xf_abort = (state == sts_pkg::ST_XFER_DELAY) && !src2_ok;
  assign rx_load  = (state == sts_pkg::ST_ON_SRC2) && src1_ok;
  assign rx_abort = (state == sts_pkg::ST_RXFER_DLY) && !src1_ok;
  assign pt_load  = ((state == sts_pkg::ST_TO_NEUT_A) && !neutral_limit_on_transfer
                     && at_neutral)
                 || ((state == sts_pkg::ST_TO_NEUT_B) && !neutral_limit_on_retransfer
                     && at_neutral);
  assign pt_value = programmed_transition ? delays.transition : sts_pkg::DELAY_ZERO;
  // a zero delay never counts, so its one-cycle run must not flash the led
  assign pt_counts = pt_value != sts_pkg::DELAY_ZERO;
  assign cd_load  = (state == sts_pkg::ST_PT_B) && !src1_limit_switch
                    && transition_motor_relay;

  // one down-counter per delay, all stepping on the shared tick
  sts_delay #(.W(DW)) u_es (
    .clock(clock),
    .rstn(rstn),
    .load(es_load),
    .value(delays.engine_start),
    .abort(es_abort),
    .tick(tick),
    .running(es_run),
    .expired(es_exp)
  );

  sts_delay #(.W(DW)) u_xf (
    .clock(clock),
    .rstn(rstn),
    .load(xf_load),
    .value(delays.transfer),
    .abort(xf_abort),
    .tick(tick),
    .running(xf_run),
    .expired(xf_exp)
  );

  sts_delay #(.W(DW)) u_rx (
    .clock(clock),
    .rstn(rstn),
    .load(rx_load),
    .value(delays.retransfer),
    .abort(rx_abort),
    .tick(tick),
    .running(rx_run),
    .expired(rx_exp)
  );

  sts_delay #(.W(DW)) u_pt (
    .clock(clock),
    .rstn(rstn),
    .load(pt_load),
    .value(pt_value),
    .abort(1'b0),
    .tick(tick),
    .running(pt_run),
    .expired(pt_exp)
  );

  sts_delay #(.W(DW)) u_cd (
    .clock(clock),
    .rstn(rstn),
    .load(cd_load),
    .value(delays.cooldown),
    .abort(src1_sense != '0 && cooling),
    .tick(tick),
    .running(cd_run),
    .expired(cd_exp)
  );

  // sequence state
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= sts_pkg::ST_ON_SRC1;
    end else begin
      case (state)
        sts_pkg::ST_ON_SRC1: begin
          if (!src1_ok) state <= sts_pkg::ST_ES_DELAY;
        end
        sts_pkg::ST_ES_DELAY: begin
          if (src1_ok) state <= sts_pkg::ST_ON_SRC1;
          else if (es_exp) state <= sts_pkg::ST_WAIT_SRC2;
        end
        sts_pkg::ST_WAIT_SRC2: begin
          if (src2_ok) state <= sts_pkg::ST_XFER_DELAY;
        end
        sts_pkg::ST_XFER_DELAY: begin
          // a dip in source two restarts its stabilising wait
          if (!src2_ok) state <= sts_pkg::ST_WAIT_SRC2;
          else if (xf_exp) state <= sts_pkg::ST_TO_NEUT_A;
        end
        sts_pkg::ST_TO_NEUT_A: begin
          if (pt_load) state <= sts_pkg::ST_PT_A;
        end
        sts_pkg::ST_PT_A: begin
          if (!transition_motor_relay || src2_limit_switch) state <= state;
          else state <= sts_pkg::ST_PT_A;
          if (transition_motor_relay && !src2_limit_switch)
            state <= sts_pkg::ST_ON_SRC2;
        end
        sts_pkg::ST_ON_SRC2: begin
          if (src1_ok) state <= sts_pkg::ST_RXFER_DLY;
        end
        sts_pkg::ST_RXFER_DLY: begin
          // a dip in source one keeps source two on the load
          if (!src1_ok) state <= sts_pkg::ST_ON_SRC2;
          else if (rx_exp) state <= sts_pkg::ST_TO_NEUT_B;
        end
        sts_pkg::ST_TO_NEUT_B: begin
          if (pt_load) state <= sts_pkg::ST_PT_B;
        end
        sts_pkg::ST_PT_B: begin
          if (transition_motor_relay && !src1_limit_switch)
            state <= sts_pkg::ST_ON_SRC1;
        end
        default: state <= sts_pkg::ST_ON_SRC1;
      endcase
    end
  end

  // motor relays: energised until the matching limit switch opens
  // limitation: a stalled motor keeps its relay up; no travel timeout here
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      transfer_motor_relay   <= 1'b0;
      retransfer_motor_relay <= 1'b0;
      transition_motor_relay <= 1'b0;
    end else begin
      transfer_motor_relay <= (state == sts_pkg::ST_TO_NEUT_A)
                              && neutral_limit_on_transfer;
      retransfer_motor_relay <= (state == sts_pkg::ST_TO_NEUT_B)
                                && neutral_limit_on_retransfer;
      if (pt_exp && (state == sts_pkg::ST_PT_A || state == sts_pkg::ST_PT_B))
        transition_motor_relay <= 1'b1;
      else if ((state == sts_pkg::ST_PT_A && !src2_limit_switch)
               || (state == sts_pkg::ST_PT_B && !src1_limit_switch)
               || state == sts_pkg::ST_TO_NEUT_A || state == sts_pkg::ST_TO_NEUT_B)
        transition_motor_relay <= 1'b0;
    end
  end

  // generator start; the relay is released to start
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      src2_started <= 1'b0;
      cooling      <= 1'b0;
    end else begin
      if (es_exp && !src1_ok) src2_started <= 1'b1;
      else if (cd_exp) src2_started <= 1'b0;
      if (cd_load) cooling <= 1'b1;
      else if (cd_exp) cooling <= 1'b0;
    end
  end

  assign engine_start_relay = ~src2_started;

  // connected indications
  // each flag moves only at a confirmed limit, never on the relay alone
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      src1_connected <= 1'b1;
      src2_connected <= 1'b0;
    end else begin
      if (state == sts_pkg::ST_TO_NEUT_A && !neutral_limit_on_transfer)
        src1_connected <= 1'b0;
      else if (state == sts_pkg::ST_PT_B && transition_motor_relay && !src1_limit_switch)
        src1_connected <= 1'b1;
      if (state == sts_pkg::ST_PT_A && transition_motor_relay && !src2_limit_switch)
        src2_connected <= 1'b1;
      else if (state == sts_pkg::ST_TO_NEUT_B && !neutral_limit_on_retransfer)
        src2_connected <= 1'b0;
    end
  end

  // events: raise wins over acknowledge in the same cycle
  // only the latest code is held; a second raise overwrites the first
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      event_active <= 1'b0;
      held_code    <= 4'h0;
    end else if (event_raise) begin
      event_active <= 1'b1;
      held_code    <= event_code;
    end else if (panel_reset) begin
      event_active <= 1'b0;
    end
  end

  sts_flasher #(.CW(sts_pkg::CODE_W)) u_flash (
    .clock(clock),
    .rstn(rstn),
    .tick(tick),
    .active(event_active),
    .code(held_code),
    .led(flash_led)
  );

  // exerciser enable; remote write wins over the local toggle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      exerciser_enabled <= 1'b0;
    end else if (exer_remote_set) begin
      exerciser_enabled <= exer_remote_value;
    end else if (exer_switch_toggle) begin
      exerciser_enabled <= ~exerciser_enabled;
    end
  end

  // indicators
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      leds <= '0;
    end else begin
      leds.health     <= event_active ? flash_led : blink;
      leds.src1_avail <= src1_ok;
      leds.src2_avail <= src2_ok;
      leds.start_src2 <= es_run ? blink : src2_started;
      // start-B: held dark in every mode; gen_to_gen and es_run are masked by a constant zero
      leds.start_src1 <= gen_to_gen && es_run && 1'b0;
      leds.retransfer <= rx_run ? blink : retransfer_motor_relay;
      leds.transfer   <= xf_run ? blink : transfer_motor_relay;
      leds.transition <= pt_run && pt_counts && blink;
      leds.exerciser  <= exerciser_enabled
                         && (exercise_period ? blink : 1'b1);
      leds.spare      <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> bench/sts_sequencer_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module sts_monitor #(
  parameter int unsigned TICK_CYCLES = 10
) (
  // clock and reset
  input wire logic                 clock,
  input wire logic                 rstn,
  // inputs
  input wire sts_pkg::sts_sensor_t src1_sense,
  input wire logic                 neutral_limit_on_transfer,
  input wire logic                 src2_limit_switch,
  input wire logic                 neutral_limit_on_retransfer,
  input wire logic                 src1_limit_switch,
  input wire logic                 at_neutral,
  input wire logic                 panel_reset,
  // outputs
  input wire logic                 engine_start_relay,
  input wire logic                 transfer_motor_relay,
  input wire logic                 retransfer_motor_relay,
  input wire logic                 transition_motor_relay,
  input wire logic                 src1_connected,
  input wire logic                 src2_connected,
  input wire logic                 event_active,
  input wire logic                 exerciser_enabled,
  input wire sts_pkg::sts_leds_t   leds
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // cycles since the heartbeat last moved; an event hands the led to the flasher
  logic [31:0] still;
  logic        last_h;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      still  <= 32'h0;
      last_h <= 1'b0;
    end else begin
      last_h <= leds.health;
      still  <= (event_active || leds.health != last_h) ? 32'h0 : still + 32'h1;
    end
  end
  chk_health_beat: assert property (still < 2 * TICK_CYCLES + 2)
    else $error("heartbeat stuck");
  chk_event_held: assert property (event_active && !panel_reset |=> event_active)
    else $error("event dropped without acknowledge");
  chk_avail_lit: assert property (!(|src1_sense) [*4] |-> leds.src1_avail)
    else $error("source one led dark");
  chk_avail_drop: assert property ((|src1_sense) [*3] |-> !leds.src1_avail)
    else $error("source one led lit on failure");
  chk_start_on_fail: assert property ($fell(engine_start_relay) |-> $past(|src1_sense))
    else $error("start with source one good");
  chk_one_motor: assert property ($onehot0({transfer_motor_relay, retransfer_motor_relay,
                                            transition_motor_relay}))
    else $error("two motor relays");
  chk_xfer_stop: assert property (transfer_motor_relay && !neutral_limit_on_transfer
                                  |-> ##[1:2] !transfer_motor_relay)
    else $error("transfer relay past neutral");
  chk_rxfer_stop: assert property (retransfer_motor_relay && !neutral_limit_on_retransfer
                                   |-> ##[1:2] !retransfer_motor_relay)
    else $error("retransfer relay past neutral");
  chk_pt_neutral: assert property ($rose(transition_motor_relay) |-> $past(at_neutral))
    else $error("transition relay off neutral");
  chk_src2_conn: assert property ($rose(src2_connected) |-> !src2_limit_switch)
    else $error("source two connected early");
  chk_src1_conn: assert property ($rose(src1_connected) |-> !src1_limit_switch)
    else $error("source one connected early");
  chk_conn_excl: assert property (!(src1_connected && src2_connected))
    else $error("both sources connected");
  chk_exer_dark: assert property (!exerciser_enabled [*3] |-> !leds.exerciser)
    else $error("exerciser led lit while disabled");
endmodule
bind sts_sequencer sts_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
  .clock(clock), .rstn(rstn), .src1_sense(src1_sense),
  .neutral_limit_on_transfer(neutral_limit_on_transfer), .src2_limit_switch(src2_limit_switch),
  .neutral_limit_on_retransfer(neutral_limit_on_retransfer),
  .src1_limit_switch(src1_limit_switch), .at_neutral(at_neutral), .panel_reset(panel_reset),
  .engine_start_relay(engine_start_relay), .transfer_motor_relay(transfer_motor_relay),
  .retransfer_motor_relay(retransfer_motor_relay),
  .transition_motor_relay(transition_motor_relay), .src1_connected(src1_connected),
  .src2_connected(src2_connected), .event_active(event_active),
  .exerciser_enabled(exerciser_enabled), .leds(leds));
`default_nettype wire

// >>> bench/sts_plant_model.sv
`timescale 1ns/10ps
`default_nettype none
module sts_plant_model (
  // clock and reset
  input  wire logic clock,
  input  wire logic rstn,
  // relays and a stuck-motor knob
  input  wire logic engine_start_relay,
  input  wire logic transfer_motor_relay,
  input  wire logic retransfer_motor_relay,
  input  wire logic transition_motor_relay,
  input  wire logic stall,
  // switches and genset
  output logic      neutral_limit_on_transfer,
  output logic      src2_limit_switch,
  output logic      neutral_limit_on_retransfer,
  output logic      src1_limit_switch,
  output logic      at_neutral,
  output logic      src2_ok
);
  // pos 0 on source one, 1 neutral, 2 on source two
  logic [1:0] pos;
  logic [1:0] from;
  logic [3:0] mv;
  logic [3:0] gen;
  logic       run;
  assign run = (transfer_motor_relay && pos == 2'h0) || (transition_motor_relay && pos == 2'h1)
             || (retransfer_motor_relay && pos == 2'h2);
  // travel takes five cycles; a stalled motor never arrives
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pos  <= 2'h0;
      from <= 2'h0;
      mv   <= 4'h0;
    end else if (!run || stall) begin
      mv <= 4'h0;
    end else if (mv == 4'h4) begin
      mv   <= 4'h0;
      from <= pos;
      pos  <= (pos != 2'h1) ? 2'h1 : ((from == 2'h0) ? 2'h2 : 2'h0);
    end else begin
      mv <= mv + 4'h1;
    end
  end
  // released relay means run; output settles some cycles after cranking
  always @(posedge clock or negedge rstn) begin
    if (!rstn) gen <= 4'h0;
    else if (engine_start_relay) gen <= 4'h0;
    else if (gen != 4'hF) gen <= gen + 4'h1;
  end
  assign src2_ok                     = gen[3];
  assign at_neutral                  = pos == 2'h1;
  assign neutral_limit_on_transfer   = !at_neutral;
  assign neutral_limit_on_retransfer = !at_neutral;
  assign src2_limit_switch           = pos != 2'h2;
  assign src1_limit_switch           = pos != 2'h0;
endmodule
`default_nettype wire

// >>> bench/test_source_transfer_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
module test_source_transfer_sequencer;
  localparam int TK = 10;
  logic                 clock = 1'b0;
  logic                 rstn = 1'b0;
  sts_pkg::sts_sensor_t src1_sense = '0;
  sts_pkg::sts_delays_t delays = {16'h0003, 16'h0002, 16'h0002, 16'h0005, 16'h0003};
  logic                 pt = 1'b1, g2g = 1'b0, ev = 1'b0, prst = 1'b0, stall = 1'b0;
  logic [3:0]           code = 4'h3;
  logic                 xtog = 1'b0, xset = 1'b0, xval = 1'b0, xper = 1'b0;
  logic                 s2ok, nlt, s2l, nlr, s1l, atn, esr, xr, rxr, tr, c1, c2, eva, xen;
  sts_pkg::sts_leds_t   leds;
  int                   errors = 0;
  int                   n_checks = 0;
  always #10 clock = ~clock;
  sts_sequencer #(.TICK_CYCLES(TK)) dut (
    .clock(clock), .rstn(rstn), .src1_sense(src1_sense), .src2_ok(s2ok), .delays(delays),
    .programmed_transition(pt), .gen_to_gen(g2g), .neutral_limit_on_transfer(nlt),
    .src2_limit_switch(s2l), .neutral_limit_on_retransfer(nlr), .src1_limit_switch(s1l),
    .at_neutral(atn), .event_raise(ev), .event_code(code), .panel_reset(prst),
    .exer_switch_toggle(xtog), .exer_remote_set(xset), .exer_remote_value(xval),
    .exercise_period(xper), .engine_start_relay(esr), .transfer_motor_relay(xr),
    .retransfer_motor_relay(rxr), .transition_motor_relay(tr), .src1_connected(c1),
    .src2_connected(c2), .event_active(eva), .exerciser_enabled(xen), .leds(leds));
  sts_plant_model plant (
    .clock(clock), .rstn(rstn), .engine_start_relay(esr), .transfer_motor_relay(xr),
    .retransfer_motor_relay(rxr), .transition_motor_relay(tr), .stall(stall),
    .neutral_limit_on_transfer(nlt), .src2_limit_switch(s2l), .neutral_limit_on_retransfer(nlr),
    .src1_limit_switch(s1l), .at_neutral(atn), .src2_ok(s2ok));
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: return esr;
      1: return xr;
      2: return tr;
      3: return rxr;
      4: return c1;
      default: return c2;
    endcase
  endfunction
  // waits for output w to reach v, counting moves of led bit li meanwhile
  task automatic await(input int w, input logic v, input int li, output int n, output int tg);
    logic last;
    n = 0;
    tg = 0;
    last = leds[li];
    while (pick(w) !== v && n < 400) begin
      cyc(1);
      n++;
      tg += int'(leds[li] !== last);
      last = leds[li];
    end
    chk(pick(w), {31'h0, v});
  endtask
  task automatic cnt(input int li, input int n, output int tg);
    logic last;
    tg = 0;
    last = leds[li];
    repeat (n) begin
      cyc(1);
      tg += int'(leds[li] !== last);
      last = leds[li];
    end
  endtask
  task automatic t_idle();
    cyc(3);
    chk(leds.src1_avail, 32'h1);
    chk(esr, 32'h1);
    chk(leds.start_src1, 32'h0);
    cyc(3 * TK);
    $display("test idle done");
  endtask
  task automatic t_blip();
    src1_sense.under_volt = 1'b1;
    cyc(3);
    chk(leds.src1_avail, 32'h0);
    cyc(TK);
    src1_sense = '0;
    cyc(5 * TK);
    chk(esr, 32'h1);
    $display("test blip done");
  endtask
  task automatic t_xfer(input logic p);
    int n, tg;
    pt = p;
    stall = !p;
    src1_sense.phase_loss = 1'b1;
    await(0, 1'b0, 6, n, tg);
    chk(n >= 2 * TK && n <= 3 * TK + 4, 32'h1);
    chk(tg >= 1, 32'h1);
    cyc(2);
    chk(leds.start_src2, 32'h1);
    await(1, 1'b1, 3, n, tg);
    chk(tg >= 1, 32'h1);
    cyc(2);
    chk(leds.transfer, 32'h1);
    if (!p) begin
      cyc(6 * TK);
      chk(tr, 32'h0);
      stall = 1'b0;
    end
    await(4, 1'b0, 2, n, tg);
    await(2, 1'b1, 2, n, tg);
    chk(p ? n >= 4 * TK : n <= 8, 32'h1);
    chk((tg != 0) == p, 32'h1);
    await(5, 1'b1, 2, n, tg);
    chk(leds.transition, 32'h0);
    $display("test transfer done");
  endtask
  task automatic t_rexfer(input logic p);
    int n, tg;
    src1_sense = '0;
    cyc(4);
    chk(leds.src1_avail, 32'h1);
    await(3, 1'b1, 4, n, tg);
    chk(tg >= 1, 32'h1);
    cyc(2);
    chk(leds.retransfer, 32'h1);
    await(5, 1'b0, 2, n, tg);
    chk(leds.src2_avail, 32'h1);
    await(2, 1'b1, 2, n, tg);
    chk((tg != 0) == p, 32'h1);
    await(4, 1'b1, 2, n, tg);
    await(0, 1'b1, 9, n, tg);
    chk(n >= 2 * TK && n <= 3 * TK + 4, 32'h1);
    $display("test retransfer done");
  endtask
  task automatic t_event();
    int tg;
    ev = 1'b1;
    cyc(1);
    ev = 1'b0;
    cyc(6 * TK);
    chk(eva, 32'h1);
    ev = 1'b1;
    prst = 1'b1;
    cyc(1);
    ev = 1'b0;
    prst = 1'b0;
    cyc(2);
    chk(eva, 32'h1);
    prst = 1'b1;
    cyc(1);
    prst = 1'b0;
    cyc(2);
    chk(eva, 32'h0);
    cnt(9, 6 * TK, tg);
    chk(tg >= 4 && tg <= 7, 32'h1);
    $display("test event done");
  endtask
  task automatic t_exer();
    int tg;
    xset = 1'b1;
    xval = 1'b1;
    cyc(1);
    xset = 1'b0;
    cyc(3);
    chk(xen, 32'h1);
    chk(leds.exerciser, 32'h1);
    xper = 1'b1;
    cnt(1, 4 * TK, tg);
    chk(tg >= 2, 32'h1);
    xper = 1'b0;
    xtog = 1'b1;
    cyc(1);
    xtog = 1'b0;
    cyc(3);
    chk(xen, 32'h0);
    chk(leds.exerciser, 32'h0);
    $display("test exerciser done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    cyc(16);
    rstn = 1'b1;
    t_idle();
    t_blip();
    t_xfer(1'b1);
    t_rexfer(1'b1);
    t_xfer(1'b0);
    t_rexfer(1'b0);
    t_event();
    t_exer();
    end_sim();
  end
  // whole run is under a thousand cycles; this limit is 20000 cycles, over twenty times that
  initial begin
    #(20 * 20000);
    errors++;
    end_sim();
  end
endmodule
`default_nettype wire
